// ===== iol_pkg.sv
// register map, reset values and widths of the io line controller
`default_nettype none
package iol_pkg;
    localparam int unsigned IOL_LINES = 32;
    localparam int unsigned IOL_AW    = 8;
    localparam int unsigned IOL_SYNC  = 2;
    typedef logic [IOL_LINES-1:0] iol_word_t;
    typedef logic [IOL_AW-1:0]    iol_addr_t;

    // byte offsets, one aligned word each
    localparam iol_addr_t IOL_OUT_SET   = 8'h00;
    localparam iol_addr_t IOL_OUT_CLR   = 8'h04;
    localparam iol_addr_t IOL_OUT_STATE = 8'h08;
    localparam iol_addr_t IOL_PIN_LEVEL = 8'h0C;
    localparam iol_addr_t IOL_IRQ_EN    = 8'h10;
    localparam iol_addr_t IOL_IRQ_DIS   = 8'h14;
    localparam iol_addr_t IOL_IRQ_MASK  = 8'h18;
    localparam iol_addr_t IOL_IRQ_FLAGS = 8'h1C;
    localparam iol_addr_t IOL_OD_EN     = 8'h20;
    localparam iol_addr_t IOL_OD_DIS    = 8'h24;
    localparam iol_addr_t IOL_OD_STATE  = 8'h28;
    localparam iol_addr_t IOL_WP_EN     = 8'h2C;
    localparam iol_addr_t IOL_WP_DIS    = 8'h30;
    localparam iol_addr_t IOL_WP_STATE  = 8'h34;
    localparam iol_addr_t IOL_FLAG_CLR  = 8'h38;

    // reset values
    localparam iol_word_t IOL_ODATA_RST = 32'h0000_0000;
    localparam iol_word_t IOL_MASK_RST  = 32'h0000_0000;
    localparam iol_word_t IOL_FLAGS_RST = 32'h0000_0000;
    localparam iol_word_t IOL_OD_RST    = 32'h0000_0000;
    localparam iol_word_t IOL_WP_RST    = 32'h0000_0000;
    localparam iol_word_t IOL_RDATA_RST = 32'h0000_0000;
    localparam iol_word_t IOL_PAD_RST   = 32'h0000_0000;
    localparam iol_word_t IOL_OE_N_RST  = 32'h0000_0000;
    localparam iol_word_t IOL_ONES      = 32'hFFFF_FFFF;
    localparam logic [2:0] IOL_PRIME_RST = 3'h0;
endpackage
`default_nettype wire

// ===== iol_port.sv
// 32-line parallel io controller: data, pin sampling, change irq, open drain
//
// Functional notes
// RL1 - set register ones drive line data high
// RL2 - clear register ones drive line data low
// RL3 - output state reads scheduled line data
// RL4 - output state always readable, writable per line
// RL5 - direct write only where permission set
// RL6 - pin level reads actual line level
// RL7 - enable register ones unmask change irq
// RL8 - disable register ones mask change irq
// RL9 - mask register shows enabled lines
// RL10 - line change sets its sticky flag
// RL11 - flag read or reset clears flags
// RL12 - open drain enable ones select open drain
// RL13 - open drain disable ones select push pull
// RL14 - open drain line only drives low
// RL15 - push pull line drives both levels
// RL16 - irq high while flagged unmasked line
// RL17 - pins synchronised, compared with previous sample
`timescale 1ns/1ps
`default_nettype none
module iol_port
    import iol_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic [IOL_AW-1:0]    addr,
    input  wire logic [IOL_LINES-1:0] wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [IOL_LINES-1:0] rdata,
    input  wire logic [IOL_LINES-1:0] pad_in,
    output logic      [IOL_LINES-1:0] pad_out,
    output logic      [IOL_LINES-1:0] pad_oe_n,
    output logic                      irq
);

    iol_word_t meta_reg;
    iol_word_t sync_reg;
    iol_word_t prev_reg;
    logic [2:0] prime_reg;
    logic [2:0] prime_next;
    iol_word_t chg;

    iol_word_t odata_reg;
    iol_word_t odata_next;
    iol_word_t mask_reg;
    iol_word_t mask_next;
    iol_word_t flags_reg;
    iol_word_t flags_next;
    iol_word_t od_reg;
    iol_word_t od_next;
    iol_word_t wp_reg;
    iol_word_t wp_next;
    iol_word_t flag_clr;
    iol_word_t rdata_reg;
    iol_word_t rdata_next;
    iol_word_t pad_out_reg;
    iol_word_t pad_out_next;
    iol_word_t oe_n_reg;
    iol_word_t oe_n_next;
    logic      irq_reg;
    logic      irq_next;

    // two-stage synchroniser; meta_reg feeds sync_reg only
    always_ff @(posedge clock or posedge rst) begin // [RL17]
        if (rst) begin
            meta_reg <= IOL_PAD_RST;
            sync_reg <= IOL_PAD_RST;
            prev_reg <= IOL_PAD_RST;
        end else begin
            meta_reg <= pad_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // compare only once sync and prev both hold real samples,
    // so the reset value of the chain is never seen as a change
    always_comb begin
        prime_next = {prime_reg[1:0], 1'b1};
        chg        = prime_reg[2] ? (sync_reg ^ prev_reg) : '0; // [RL17]
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prime_reg <= IOL_PRIME_RST;
        end else begin
            prime_reg <= prime_next;
        end
    end

    // register writes; set beats clear on flags
    always_comb begin
        odata_next = odata_reg;
        mask_next  = mask_reg;
        od_next    = od_reg;
        wp_next    = wp_reg;
        flag_clr   = '0;
        if (wr) begin
            case (addr)
                IOL_OUT_SET: begin
                    odata_next = odata_reg | wdata; // [RL1]
                end
                IOL_OUT_CLR: begin
                    odata_next = odata_reg & ~wdata; // [RL2]
                end
                IOL_OUT_STATE: begin
                    // lines without permission keep their data
                    odata_next = (odata_reg & ~wp_reg) | (wdata & wp_reg); // [RL4] [RL5]
                end
                IOL_IRQ_EN: begin
                    mask_next = mask_reg | wdata; // [RL7]
                end
                IOL_IRQ_DIS: begin
                    mask_next = mask_reg & ~wdata; // [RL8]
                end
                IOL_OD_EN: begin
                    od_next = od_reg | wdata; // [RL12]
                end
                IOL_OD_DIS: begin
                    od_next = od_reg & ~wdata; // [RL13]
                end
                IOL_WP_EN: begin
                    wp_next = wp_reg | wdata;
                end
                IOL_WP_DIS: begin
                    wp_next = wp_reg & ~wdata;
                end
                IOL_FLAG_CLR: begin
                    flag_clr = wdata;
                end
                default: begin
                end
            endcase
        end
        if (rd && addr == IOL_IRQ_FLAGS) begin
            flag_clr = IOL_ONES; // [RL11]
        end
        // a change in the clearing cycle survives
        flags_next = (flags_reg & ~flag_clr) | chg; // [RL10]
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            odata_reg <= IOL_ODATA_RST;
            mask_reg  <= IOL_MASK_RST;
            flags_reg <= IOL_FLAGS_RST; // [RL11]
            od_reg    <= IOL_OD_RST;
            wp_reg    <= IOL_WP_RST;
        end else begin
            odata_reg <= odata_next;
            mask_reg  <= mask_next;
            flags_reg <= flags_next;
            od_reg    <= od_next;
            wp_reg    <= wp_next;
        end
    end

    // read data stands one cycle only; write-only words read zero
    always_comb begin
        rdata_next = '0;
        if (rd) begin
            case (addr)
                IOL_OUT_STATE: rdata_next = odata_reg; // [RL3] [RL4]
                IOL_PIN_LEVEL: rdata_next = sync_reg; // [RL6]
                IOL_IRQ_MASK:  rdata_next = mask_reg; // [RL9]
                IOL_IRQ_FLAGS: rdata_next = flags_reg;
                IOL_OD_STATE:  rdata_next = od_reg; // [RL14] [RL15]
                IOL_WP_STATE:  rdata_next = wp_reg;
                default:       rdata_next = '0;
            endcase
        end
    end

    // pad drive: open drain releases instead of driving high
    always_comb begin
        pad_out_next = odata_next & ~od_next; // [RL14] [RL15]
        oe_n_next    = od_next & odata_next; // [RL14] [RL15]
        irq_next     = |(flags_next & mask_next); // [RL16]
    end

    // outputs registered; pads follow data one cycle after the write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg   <= IOL_RDATA_RST;
            pad_out_reg <= IOL_PAD_RST;
            oe_n_reg    <= IOL_OE_N_RST;
            irq_reg     <= 1'b0;
        end else begin
            rdata_reg   <= rdata_next;
            pad_out_reg <= pad_out_next;
            oe_n_reg    <= oe_n_next;
            irq_reg     <= irq_next;
        end
    end

    assign rdata    = rdata_reg;
    assign pad_out  = pad_out_reg;
    assign pad_oe_n = oe_n_reg;
    assign irq      = irq_reg;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_set;
        wr && addr == IOL_OUT_SET |=> (odata_reg & $past(wdata)) == $past(wdata);
    endproperty
    a_set: assert property (p_set) else $error("set write missed"); // [RL1]

    property p_clr;
        wr && addr == IOL_OUT_CLR |=> (odata_reg & $past(wdata)) == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear write missed"); // [RL2]

    property p_keep;
        wr && (addr == IOL_OUT_SET || addr == IOL_OUT_CLR)
        |=> ((odata_reg ^ $past(odata_reg)) & ~$past(wdata)) == '0;
    endproperty
    a_keep: assert property (p_keep) else $error("zero bit changed data"); // [RL1] [RL2]

    property p_odsr_rd;
        rd && addr == IOL_OUT_STATE |=> rdata == $past(odata_reg);
    endproperty
    a_odsr_rd: assert property (p_odsr_rd) else $error("output state readback wrong"); // [RL3]

    property p_direct;
        wr && addr == IOL_OUT_STATE |=> odata_reg ==
            (($past(odata_reg) & ~$past(wp_reg)) | ($past(wdata) & $past(wp_reg)));
    endproperty
    a_direct: assert property (p_direct) else $error("direct write wrong"); // [RL4] [RL5]

    property p_pin_rd;
        rd && addr == IOL_PIN_LEVEL |=> rdata == $past(pad_in, 3);
    endproperty
    a_pin_rd: assert property (p_pin_rd) else $error("pin level wrong"); // [RL6] [RL17]

    property p_mask_en;
        wr && addr == IOL_IRQ_EN |=> (mask_reg & $past(wdata)) == $past(wdata);
    endproperty
    a_mask_en: assert property (p_mask_en) else $error("irq enable missed"); // [RL7]

    property p_mask_dis;
        wr && addr == IOL_IRQ_DIS |=> (mask_reg & $past(wdata)) == '0;
    endproperty
    a_mask_dis: assert property (p_mask_dis) else $error("irq disable missed"); // [RL8]

    property p_mask_rd;
        rd && addr == IOL_IRQ_MASK |=> rdata == $past(mask_reg);
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong"); // [RL9]

    property p_flag_set;
        chg != '0 |=> (flags_reg & $past(chg)) == $past(chg);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("change not flagged"); // [RL10]

    property p_flag_rd;
        rd && addr == IOL_IRQ_FLAGS && chg == '0 |=> (flags_reg == '0) && !irq;
    endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flags not cleared"); // [RL11] [RL16]

    property p_od_low;
        (pad_out & od_reg) == '0;
    endproperty
    a_od_low: assert property (p_od_low) else $error("open drain drove high"); // [RL14]

    property p_pp;
        ((oe_n_reg | (pad_out ^ odata_reg)) & ~od_reg) == '0;
    endproperty
    a_pp: assert property (p_pp) else $error("push pull drive wrong"); // [RL15]

    property p_od_st;
        wr && addr == IOL_OD_EN |=> (od_reg & $past(wdata)) == $past(wdata);
    endproperty
    a_od_st: assert property (p_od_st) else $error("open drain enable missed"); // [RL12]

    property p_pp_st;
        wr && addr == IOL_OD_DIS |=> (od_reg & $past(wdata)) == '0;
    endproperty
    a_pp_st: assert property (p_pp_st) else $error("open drain disable missed"); // [RL13]

    property p_irq;
        irq == (|(flags_reg & mask_reg));
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised"); // [RL16]

    // read data is zero outside the cycle after a read
    property p_rd_idle;
        !rd |=> rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle read data not zero"); // [RL3]

    property p_flags_rd;
        rd && addr == IOL_IRQ_FLAGS |=> rdata == $past(flags_reg);
    endproperty
    a_flags_rd: assert property (p_flags_rd) else $error("flag readback wrong"); // [RL10]

    property p_od_rd;
        rd && addr == IOL_OD_STATE |=> rdata == $past(od_reg);
    endproperty
    a_od_rd: assert property (p_od_rd) else $error("open drain readback wrong"); // [RL14] [RL15]

    property p_wp_rd;
        rd && addr == IOL_WP_STATE |=> rdata == $past(wp_reg);
    endproperty
    a_wp_rd: assert property (p_wp_rd) else $error("permission readback wrong"); // [RL5]

    // permission bits follow their enable and disable words
    property p_wp_en;
        wr && addr == IOL_WP_EN |=> (wp_reg & $past(wdata)) == $past(wdata);
    endproperty
    a_wp_en: assert property (p_wp_en) else $error("permission enable missed"); // [RL5]

    property p_wp_dis;
        wr && addr == IOL_WP_DIS |=> (wp_reg & $past(wdata)) == '0;
    endproperty
    a_wp_dis: assert property (p_wp_dis) else $error("permission disable missed"); // [RL5]

    // state moves only on a write to its own words
    property p_data_hold;
        !(wr && (addr == IOL_OUT_SET || addr == IOL_OUT_CLR || addr == IOL_OUT_STATE))
        |=> odata_reg == $past(odata_reg);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("line data moved alone"); // [RL3]

    property p_mask_hold;
        !(wr && (addr == IOL_IRQ_EN || addr == IOL_IRQ_DIS))
        |=> mask_reg == $past(mask_reg);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask moved alone"); // [RL9]

    // flags are sticky and rise only on a detected change
    property p_flag_hold;
        !(rd && addr == IOL_IRQ_FLAGS) && !(wr && addr == IOL_FLAG_CLR)
        |=> (flags_reg & $past(flags_reg)) == $past(flags_reg);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear"); // [RL10]

    property p_flag_only;
        (flags_reg & ~$past(flags_reg) & ~$past(chg)) == '0;
    endproperty
    a_flag_only: assert property (p_flag_only) else $error("flag set without change"); // [RL10]

    property p_flag_win;
        rd && addr == IOL_IRQ_FLAGS |=> flags_reg == $past(chg);
    endproperty
    a_flag_win: assert property (p_flag_win) else $error("change lost in clearing read"); // [RL11]

    property p_flag_clr;
        wr && addr == IOL_FLAG_CLR |=> (flags_reg & $past(wdata) & ~$past(chg)) == '0;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag clear missed"); // [RL11]

    // open drain: enable mirrors data, so a one releases the pin
    property p_od_drive;
        ((oe_n_reg ^ odata_reg) & od_reg) == '0;
    endproperty
    a_od_drive: assert property (p_od_drive) else $error("open drain enable wrong"); // [RL14]

    // synchroniser stages one edge apart, checked once primed
    property p_sync;
        prime_reg[1] |-> sync_reg == $past(pad_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser delay wrong"); // [RL17]

    property p_prev;
        prev_reg == $past(sync_reg);
    endproperty
    a_prev: assert property (p_prev) else $error("previous sample wrong"); // [RL17]

    c_set: cover property (wr && addr == IOL_OUT_SET ##1 odata_reg != '0);
    c_flag: cover property (flags_reg != '0 ##1 rd && addr == IOL_IRQ_FLAGS);
    c_od: cover property ((od_reg & ~oe_n_reg) != '0);
    c_irq: cover property (irq ##[1:4] !irq);
    c_win: cover property (rd && addr == IOL_IRQ_FLAGS && chg != '0);

endmodule // iol_port
`default_nettype wire

// ===== iol_port_note_end.sv
// intentionally empty companion unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== iol_ext_model.sv
// far side of the io pins: pull-ups plus an open-drain driver per line
`timescale 1ns/1ps
`default_nettype none
module iol_ext_model
    import iol_pkg::*;
(
    input  wire logic [IOL_LINES-1:0] pad_out,
    input  wire logic [IOL_LINES-1:0] pad_oe_n,
    input  wire logic [IOL_LINES-1:0] ext_low,
    output logic      [IOL_LINES-1:0] pad_in
);
    // wired and: a released line floats to the pull-up, any party may pull low
    // limitation: a push-pull high fought by ext_low just reads low here
    assign pad_in = (pad_out | pad_oe_n) & ~ext_low;
endmodule // iol_ext_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the io line controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import iol_pkg::*;
;
    typedef struct {logic w; iol_addr_t a; iol_word_t d;} iol_row_s;
    logic      clock;
    logic      rst;
    logic      wr;
    logic      rd;
    logic      irq;
    iol_addr_t addr;
    iol_word_t wdata;
    iol_word_t rdata;
    iol_word_t pad_in;
    iol_word_t pad_out;
    iol_word_t pad_oe_n;
    iol_word_t ext_low;
    int        n_fail;
    int        num_checks;
    int        i;
    // ordinary register cases: write rows, then read rows with expected data
    iol_row_s  rows [21] = '{
        '{1'h1, IOL_OUT_SET,   32'hA5A5_0F0F},
        '{1'h0, IOL_OUT_STATE, 32'hA5A5_0F0F},
        '{1'h1, IOL_OUT_CLR,   32'h0000_0F00},
        '{1'h0, IOL_OUT_STATE, 32'hA5A5_000F},
        '{1'h1, IOL_OUT_STATE, 32'hFFFF_FFFF},
        '{1'h0, IOL_OUT_STATE, 32'hA5A5_000F},
        '{1'h1, IOL_WP_EN,     32'h0000_00FF},
        '{1'h1, IOL_OUT_STATE, 32'h0000_0030},
        '{1'h0, IOL_OUT_STATE, 32'hA5A5_0030},
        '{1'h1, IOL_IRQ_EN,    32'h0000_0003},
        '{1'h1, IOL_IRQ_DIS,   32'h0000_0002},
        '{1'h0, IOL_IRQ_MASK,  32'h0000_0001},
        '{1'h1, IOL_OD_EN,     32'h0000_0003},
        '{1'h1, IOL_OD_DIS,    32'h0000_0002},
        '{1'h0, IOL_OD_STATE,  32'h0000_0001},
        '{1'h0, IOL_PIN_LEVEL, 32'hA5A5_0030},
        '{1'h0, 8'h3C,         32'h0000_0000},
        '{1'h0, IOL_OUT_SET,   32'h0000_0000},
        '{1'h0, IOL_WP_STATE,  32'h0000_00FF},
        '{1'h1, IOL_WP_DIS,    32'h0000_000F},
        '{1'h0, IOL_WP_STATE,  32'h0000_00F0}
    };

    iol_port i_iol_port (
        .clock    (clock),
        .rst      (rst),
        .addr     (addr),
        .wdata    (wdata),
        .wr       (wr),
        .rd       (rd),
        .rdata    (rdata),
        .pad_in   (pad_in),
        .pad_out  (pad_out),
        .pad_oe_n (pad_oe_n),
        .irq      (irq)
    );

    iol_ext_model i_iol_ext_model (
        .pad_out  (pad_out),
        .pad_oe_n (pad_oe_n),
        .ext_low  (ext_low),
        .pad_in   (pad_in)
    );

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input iol_word_t got, input iol_word_t exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle strobes, launched right after an edge
    task automatic wr_reg(input iol_addr_t a, input iol_word_t d);
        @(posedge clock);
        wr    <= 1'h1;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'h0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input iol_addr_t a, input iol_word_t exp);
        @(posedge clock);
        rd   <= 1'h1;
        addr <= a;
        @(posedge clock);
        rd <= 1'h0;
        #1;
        check(rdata, exp);
    endtask

    // bounded wait: an interrupt still low after 20 cycles ends the run
    task automatic wait_irq();
        // look off the edge so the registered irq has settled
        for (i = 0; i < 20 && irq !== 1'h1; i++) begin
            @(posedge clock);
            #1;
        end
        check(32'(irq), 32'h0000_0001);
        if (irq !== 1'h1) begin
            close_out();
        end
    endtask

    initial begin
        rst        = 1'h1;
        wr         = 1'h0;
        rd         = 1'h0;
        addr       = 8'h00;
        wdata      = 32'h0000_0000;
        ext_low    = 32'h0000_0000;
        n_fail     = 0;
        num_checks = 0;
        repeat (8) @(posedge clock);
        rst <= 1'h0;
        foreach (rows[k]) begin
            if (rows[k].w === 1'h1) begin
                wr_reg(rows[k].a, rows[k].d);
            end else begin
                rd_reg(rows[k].a, rows[k].d);
            end
        end
        // line 0 open drain released, line 1 push-pull driven high
        wr_reg(IOL_OUT_SET, 32'h0000_0003);
        check(32'({pad_oe_n[1:0], pad_out[1:0]}), 32'h0000_0006);
        repeat (6) @(posedge clock);
        wr_reg(IOL_FLAG_CLR, IOL_ONES);
        check(32'(irq), 32'h0000_0000);
        // far side pulls the released line low
        ext_low <= 32'h0000_0001;
        wait_irq();
        rd_reg(IOL_IRQ_FLAGS, 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        rd_reg(IOL_IRQ_FLAGS, 32'h0000_0000);
        // masked line still flags but keeps the interrupt low
        wr_reg(IOL_IRQ_DIS, 32'h0000_0001);
        ext_low <= 32'h0000_0000;
        repeat (8) @(posedge clock);
        check(32'(irq), 32'h0000_0000);
        rd_reg(IOL_IRQ_FLAGS, 32'h0000_0001);
        // change lands in the clearing read cycle: set beats clear
        ext_low <= 32'h0000_0001;
        @(posedge clock);
        rd_reg(IOL_IRQ_FLAGS, 32'h0000_0000);
        rd_reg(IOL_IRQ_FLAGS, 32'h0000_0001);
        // second reset in mid-run
        rst <= 1'h1;
        @(posedge clock);
        #1;
        check(pad_out | pad_oe_n | rdata | 32'(irq), 32'h0000_0000);
        repeat (2) @(posedge clock);
        rst <= 1'h0;
        rd_reg(IOL_OUT_STATE, 32'h0000_0000);
        rd_reg(IOL_IRQ_MASK, 32'h0000_0000);
        rd_reg(IOL_IRQ_FLAGS, 32'h0000_0000);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
